// File: src/chsf_defs.svh
// Register offsets, bit positions, reset values and counts of the card host status flags
`ifndef CHSF_DEFS_SVH
`define CHSF_DEFS_SVH
`define CHSF_OFF_STATUS 8'h00
`define CHSF_OFF_INT_STAT 8'h04
`define CHSF_OFF_INT_MASK 8'h08
`define CHSF_OFF_CTRL 8'h0C
`define CHSF_B_RD_TIMEOUT 0
`define CHSF_B_RSP_TIMEOUT 1
`define CHSF_B_WR_CRC_LO 2
`define CHSF_B_WR_CRC_HI 3
`define CHSF_B_RD_CRC 4
`define CHSF_B_RSP_CRC 5
`define CHSF_B_FIFO_EMPTY 6
`define CHSF_B_FIFO_FULL 7
`define CHSF_B_READ_WAIT 8
`define CHSF_B_FIFO_AFULL 9
`define CHSF_B_CMD_END 10
`define CHSF_B_XFER_DONE 11
`define CHSF_B_PROG_DONE 12
`define CHSF_B_SDIO_INT 13
`define CHSF_B_RESETTING 15
`define CHSF_B_CTRL_RESET 0
`define CHSF_AFULL_WORDS 15
`define CHSF_FIFO_DEPTH 16
`define CHSF_RESET_CYCLES 16
`define CHSF_RST_STATUS 32'h0000_0000
`define CHSF_RST_MASK 32'h0000_0000
`define CHSF_INT_BITS 32'h0000_3C3F
`endif

// File: src/chsf_pkg.sv
// Types shared by the card host status flags block
package chsf_pkg;
  // Event and level inputs from the command and data engines; the FIFO count comes in on its own port
  typedef struct packed {
    logic cmdStart;
    logic cmdEnd;
    logic xferDone;
    logic respCrcFail;
    logic readCrcFail;
    logic wrCrcValid;
    logic [1:0] wrCrcCode;
    logic respTimeout;
    logic readTimeout;
    logic busyExpected;
    logic readWait;
    logic sdioAck;
  } chsf_evt_t;
  // Gray order along the usual path
  typedef enum logic [1:0] {
    RS_RESETTING = 2'b00,
    RS_DONE = 2'b01
  } chsf_rst_state_t;
endpackage

// File: src/chsf_status.sv
// Card host controller status flags with register port and interrupt
// Notes on behaviour
// - Resetting flag is 1 from power-up or software reset until reset completes.
// - Card interrupt flag rises on SDIO interrupt, stays until acknowledge sent.
// - Programming-done reads 0 while card busy, 1 when no longer busy.
// - Transfer-done is 1 once data transmission completes, 0 while in progress.
// - Command-end is 1 when the command sequence completes, with or without response.
// - Almost-full flag set while FIFO holds 15 words or more.
// - FIFO-empty reads 1 when FIFO holds no word, else 0.
// - Status bit 5 flags a response CRC failure.
// - Status bit 4 flags a read data CRC failure.
// - Bits 3:2 give write CRC status: 00 ok, 01 bad, 10 no token.
// - Status bit 1 flags a response timeout.
// - Status bit 0 flags a read data timeout.
// - FIFO-full flag reads 1 when the FIFO is full.
`timescale 1ns/1ps
`default_nettype none
`include "chsf_defs.svh"

module chsf_status #(
  parameter int FIFO_DEPTH = `CHSF_FIFO_DEPTH,
  parameter int AFULL_WORDS = `CHSF_AFULL_WORDS,
  parameter int RESET_CYCLES = `CHSF_RESET_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  output logic irq,
  output logic resetActive,
  input wire chsf_pkg::chsf_evt_t engineEvt,
  input wire logic [4:0] fifoCount,
  input wire logic linkClk,
  input wire logic cardDat0,
  input wire logic cardDat1
);
  import chsf_pkg::*;

  // Register map
  // 0x00 status, read only
  // 0x04 interrupt status, write one to clear
  // 0x08 interrupt mask, same layout as interrupt status
  // 0x0C control, bit 0 restarts the controller reset, reads 0
  // Status layout
  // Bit 0 read timeout, bit 1 response timeout, bits 3:2 write CRC code
  // Bit 4 read CRC fail, bit 5 response CRC fail, bit 6 FIFO empty, bit 7 FIFO full
  // Bit 8 read wait, bit 9 almost full, bit 10 command end, bit 11 transfer done
  // Bit 12 programming done, bit 13 SDIO interrupt, bit 15 resetting
  // Bit 14 and bits 31:16 read 0

  // ****************************************
  // Pin synchronisers and link edge
  // ****************************************
  logic [2:0] pinMeta_q;
  logic [2:0] pinSync_q;
  logic linkPrev_q;
  wire logic linkRise;
  wire logic dat0Level;
  wire logic dat1Level;

  // Reset to idle levels: data lines are pulled up, so no busy or interrupt shows
  // The link clock parks low; a reset value of 1 can only look like a fall, never a rise
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pinMeta_q <= 3'h7;
      pinSync_q <= 3'h7;
      linkPrev_q <= 1'b1;
    end
    else
    begin
      pinMeta_q <= {cardDat1, cardDat0, linkClk};
      pinSync_q <= pinMeta_q;
      linkPrev_q <= pinSync_q[0];
    end
  end

  // Card lines are valid at the rising link edge, so DAT1 is sampled only there; DAT0 busy is taken every cycle
  assign linkRise = pinSync_q[0] & ~linkPrev_q;
  assign dat0Level = pinSync_q[1];
  assign dat1Level = pinSync_q[2];
  // Limitation: SDIO interrupts are only seen while the link clock runs

  // ****************************************
  // Register decode
  // ****************************************
  wire logic selStatus;
  wire logic selIntStat;
  wire logic selIntMask;
  wire logic selCtrl;
  wire logic swResetReq;

  // Addresses are full byte offsets, so upper bits never alias a register
  assign selStatus = regAddr == `CHSF_OFF_STATUS;
  assign selIntStat = regAddr == `CHSF_OFF_INT_STAT;
  assign selIntMask = regAddr == `CHSF_OFF_INT_MASK;
  assign selCtrl = regAddr == `CHSF_OFF_CTRL;
  assign swResetReq = regWr & selCtrl & regWrData[`CHSF_B_CTRL_RESET];

  // ****************************************
  // Reset sequencer
  // ****************************************
  chsf_rst_state_t rstState_q;
  chsf_rst_state_t rstState_d;
  logic [15:0] rstCnt_q;
  logic [15:0] rstCnt_d;
  wire logic seqReset;

  // Power-up and software reset share one sequence, so software sees one behaviour
  // A software request while the count runs is ignored; the count stops at its last value
  always_comb
  begin
    rstState_d = rstState_q;
    rstCnt_d = rstCnt_q;
    case (rstState_q)
      RS_RESETTING:
      begin
        if (rstCnt_q == 16'(RESET_CYCLES - 1))
        begin
          rstState_d = RS_DONE;
        end
        else
        begin
          rstCnt_d = rstCnt_q + 16'h0001;
        end
      end
      RS_DONE:
      begin
        if (swResetReq)
        begin
          rstState_d = RS_RESETTING;
          rstCnt_d = 16'h0000;
        end
      end
      default:
      begin
        rstState_d = RS_RESETTING;
        rstCnt_d = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rstState_q <= RS_RESETTING;
      rstCnt_q <= 16'h0000;
    end
    else
    begin
      rstState_q <= rstState_d;
      rstCnt_q <= rstCnt_d;
    end
  end

  // Flags are held clear for the whole software reset, as for power-up
  assign seqReset = rstState_q == RS_RESETTING;

  // ****************************************
  // Status flags
  // ****************************************
  logic [31:0] status_q;
  logic [31:0] status_d;
  wire logic cardIrqSeen;
  wire logic cardBusy;
  wire logic newCmd;

  // Engine events come from logic on this clock, so they are used unsynchronised
  // An SDIO card interrupt is DAT1 held low while the card is idle
  assign cardIrqSeen = linkRise & ~dat1Level;
  assign cardBusy = engineEvt.busyExpected & ~dat0Level;
  assign newCmd = engineEvt.cmdStart;

  always_comb
  begin
    status_d = `CHSF_RST_STATUS;
    status_d[`CHSF_B_RESETTING] = seqReset;
    if (!seqReset)
    begin
      // Level flags follow their source one edge later; sticky ones hold until a new command, the SDIO interrupt until acknowledge
      // A set arriving with a new command wins over its clear
      status_d[`CHSF_B_SDIO_INT] = cardIrqSeen |
        (status_q[`CHSF_B_SDIO_INT] & ~engineEvt.sdioAck);
      status_d[`CHSF_B_PROG_DONE] = ~cardBusy;
      status_d[`CHSF_B_XFER_DONE] = engineEvt.xferDone |
        (status_q[`CHSF_B_XFER_DONE] & ~newCmd);
      status_d[`CHSF_B_CMD_END] = engineEvt.cmdEnd |
        (status_q[`CHSF_B_CMD_END] & ~newCmd);
      status_d[`CHSF_B_FIFO_AFULL] = fifoCount >= 5'(AFULL_WORDS);
      status_d[`CHSF_B_READ_WAIT] = engineEvt.readWait;
      status_d[`CHSF_B_FIFO_FULL] = fifoCount >= 5'(FIFO_DEPTH);
      status_d[`CHSF_B_FIFO_EMPTY] = fifoCount == 5'h00;
      status_d[`CHSF_B_RSP_CRC] = engineEvt.respCrcFail |
        (status_q[`CHSF_B_RSP_CRC] & ~newCmd);
      status_d[`CHSF_B_RD_CRC] = engineEvt.readCrcFail |
        (status_q[`CHSF_B_RD_CRC] & ~newCmd);
      // Write CRC code holds unless a new code arrives or a new command starts
      if (engineEvt.wrCrcValid)
      begin
        status_d[`CHSF_B_WR_CRC_HI:`CHSF_B_WR_CRC_LO] = engineEvt.wrCrcCode;
      end
      else if (!newCmd)
      begin
        status_d[`CHSF_B_WR_CRC_HI:`CHSF_B_WR_CRC_LO] =
          status_q[`CHSF_B_WR_CRC_HI:`CHSF_B_WR_CRC_LO];
      end
      status_d[`CHSF_B_RSP_TIMEOUT] = engineEvt.respTimeout |
        (status_q[`CHSF_B_RSP_TIMEOUT] & ~newCmd);
      status_d[`CHSF_B_RD_TIMEOUT] = engineEvt.readTimeout |
        (status_q[`CHSF_B_RD_TIMEOUT] & ~newCmd);
    end
  end

  // No write path reaches this register
  // Flags are clear during reset; the resetting bit rises on the first edge after it
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      status_q <= `CHSF_RST_STATUS;
    end
    else
    begin
      status_q <= status_d;
    end
  end

  // ****************************************
  // Interrupt status and mask
  // ****************************************
  logic [31:0] intStat_q;
  logic [31:0] intStat_d;
  logic [31:0] intMask_q;
  wire logic [31:0] intRise;
  wire logic [31:0] intClr;
  wire logic maskWr;
  wire logic [31:0] intMask_d;
  wire logic [31:0] irqPend;

  // Events are rising edges of the sticky flags and programming done; FIFO and read-wait levels raise none
  assign intRise = status_d & ~status_q & `CHSF_INT_BITS;
  assign intClr = (regWr & selIntStat) ? regWrData : 32'h0000_0000;
  assign maskWr = regWr & selIntMask;
  // Only bits that can raise an event are stored, the rest read 0
  assign intMask_d = maskWr ? (regWrData & `CHSF_INT_BITS) : intMask_q;
  // Next interrupt status is used so that irq follows its event by one edge
  assign irqPend = intStat_d & intMask_q;

  // Writing one clears a bit; an event in the same cycle wins
  always_comb
  begin
    intStat_d = intRise | (intStat_q & ~intClr);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      intStat_q <= 32'h0000_0000;
      intMask_q <= `CHSF_RST_MASK;
      irq <= 1'b0;
    end
    else
    begin
      intStat_q <= intStat_d;
      intMask_q <= intMask_d;
      irq <= |irqPend;
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  wire logic [31:0] rdMux;

  // Control register is write only and reads 0, as do unmapped offsets
  assign rdMux = selStatus ? status_q :
                 selIntStat ? intStat_q :
                 selIntMask ? intMask_q :
                 32'h0000_0000;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      regRdData <= 32'h0000_0000;
      resetActive <= 1'b1;
    end
    else
    begin
      // Data stands for one cycle only, zero otherwise
      regRdData <= regRd ? rdMux : 32'h0000_0000;
      // Registered copy of the sequencer state for the pin
      resetActive <= seqReset;
    end
  end
endmodule
`default_nettype wire

// File: bench/chsf_properties.sv
// Concurrent checks on the card host status flags
`timescale 1ns/1ps
`default_nettype none
module chsf_properties (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdData,
  input wire logic resetActive,
  input wire chsf_pkg::chsf_evt_t engineEvt,
  input wire logic [4:0] fifoCount
);
  import chsf_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ****
  // Status reads
  // ****
  sequence statRd;
    regRd && regAddr == 8'h00 && !resetActive && !engineEvt.cmdStart;
  endsequence
  // An event must be visible to a status read in the very next cycle
  property sets(logic e, int b);
    !resetActive && e ##1 statRd |=> regRdData[b];
  endproperty
  cmd_end_a: assert property (sets(engineEvt.cmdEnd, 10)) else $error("cmd end");
  xfer_done_a: assert property (sets(engineEvt.xferDone, 11)) else $error("xfer");
  rsp_crc_a: assert property (sets(engineEvt.respCrcFail, 5)) else $error("rsp crc");
  rd_crc_a: assert property (sets(engineEvt.readCrcFail, 4)) else $error("rd crc");
  rsp_tmo_a: assert property (sets(engineEvt.respTimeout, 1)) else $error("rsp tmo");
  rd_tmo_a: assert property (sets(engineEvt.readTimeout, 0)) else $error("rd tmo");
  fifo_empty_a: assert property (statRd ##0 $stable(fifoCount) && !$past(resetActive)
    |=> regRdData[6] == ($past(fifoCount) == 0)) else $error("empty");
  soft_reset_a: assert property (regWr && regAddr == 8'h0C && regWrData[0]
    |-> ##[2:3] resetActive) else $error("soft reset");
endmodule
bind chsf_status chsf_properties u_props (
  .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
  .regRd(regRd), .regRdData(regRdData), .resetActive(resetActive), .engineEvt(engineEvt),
  .fifoCount(fifoCount)
);
`default_nettype wire

// File: bench/chsf_card_model.sv
// Card side of the link: clock within frames, pulled-up data lines
`timescale 1ns/1ps
`default_nettype none
module chsf_card_model (
  input wire logic clkOn,
  input wire logic busy,
  input wire logic intReq,
  output logic linkClk,
  output logic cardDat0,
  output logic cardDat1
);
  // Clock parks between frames instead of running free
  initial linkClk = 1'b0;
  always #100 if (clkOn) linkClk = ~linkClk;
  // Released lines float up to the pull-up level
  assign cardDat0 = !busy;
  assign cardDat1 = !intReq;
endmodule
`default_nettype wire

// File: bench/chsf_status_bench.sv
// Self-checking bench for the card host status flags
`timescale 1ns/1ps
`default_nettype none
module chsf_status_bench;
  import chsf_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0000_0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdData;
  logic irq;
  logic resetActive;
  chsf_evt_t engineEvt = '0;
  chsf_evt_t base = '0;
  logic [4:0] fifoCount = 5'h00;
  logic clkOn = 1'b0;
  logic busy = 1'b0;
  logic intReq = 1'b0;
  logic linkClk;
  logic cardDat0;
  logic cardDat1;
  int bad_count = 0;
  int cmp_count = 0;
  int pos[6] = '{10, 11, 5, 4, 1, 0};
  int ep[6] = '{11, 10, 9, 8, 4, 3};
  logic [4:0] fc[4] = '{5'h00, 5'h0E, 5'h0F, 5'h10};
  logic [31:0] fx[4] = '{32'h0000_0040, 32'h0000_0000, 32'h0000_0200, 32'h0000_0280};
  logic [31:0] bm = 32'h0000_0000;
  always #12.5 sys_clk = ~sys_clk;
  chsf_status #(.RESET_CYCLES(8)) u_dut (
    .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .irq(irq), .resetActive(resetActive),
    .engineEvt(engineEvt), .fifoCount(fifoCount), .linkClk(linkClk), .cardDat0(cardDat0),
    .cardDat1(cardDat1)
  );
  chsf_card_model u_card (
    .clkOn(clkOn), .busy(busy), .intReq(intReq), .linkClk(linkClk), .cardDat0(cardDat0),
    .cardDat1(cardDat1)
  );
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    engineEvt <= base;
    @(posedge sys_clk);
    regRd <= 1'b0;
    // Data launched at the strobe edge still stands until the next edge updates it
    @(posedge sys_clk);
    chk(regRdData & m, e);
  endtask
  // Event lands one cycle ahead of the read strobe
  task automatic evRd(input chsf_evt_t v, input logic [31:0] m, input logic [31:0] e);
    @(posedge sys_clk);
    engineEvt <= v;
    rd(8'h00, m, e);
  endtask
  task automatic waitReset();
    for (int n = 0; resetActive !== 1'b0; n++)
    begin
      if (n == 50)
      begin
        bad_count++;
        report_and_stop();
      end
      @(posedge sys_clk);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  initial
  begin
    tick(6);
    chk(32'(resetActive), 32'h0000_0001);
    rst <= 1'b0;
    rd(8'h00, 32'hFFFF_FFFF, 32'h0000_8000);
    waitReset();
    $display("reset test done");
    foreach (fc[i])
    begin
      fifoCount <= fc[i];
      rd(8'h00, 32'h0000_02C0, fx[i]);
    end
    foreach (pos[i])
    begin
      bm = 32'h0000_0001 << pos[i];
      evRd(chsf_evt_t'(13'h0001 << ep[i]), bm, bm);
      rd(8'h00, bm, bm);
      evRd(chsf_evt_t'(13'h1000), bm, 32'h0000_0000);
    end
    evRd(chsf_evt_t'(13'h0002), 32'h0000_0100, 32'h0000_0100);
    rd(8'h00, 32'h0000_0100, 32'h0000_0000);
    for (int c = 0; c < 3; c++)
      evRd(chsf_evt_t'(13'(13'h1080 | (c << 5))), 32'h0000_000C, 32'(c) << 2);
    wr(8'h00, 32'hFFFF_FFFF);
    rd(8'h00, 32'h0000_003F, 32'h0000_0008);
    $display("flag test done");
    wr(8'h04, 32'hFFFF_FFFF);
    wr(8'h08, 32'h0000_0400);
    evRd(chsf_evt_t'(13'h0800), 32'h0000_0400, 32'h0000_0400);
    tick(2);
    chk(32'(irq), 32'h0000_0001);
    rd(8'h04, 32'hFFFF_FFFF, 32'h0000_0400);
    wr(8'h08, 32'h0000_0000);
    tick(2);
    chk(32'(irq), 32'h0000_0000);
    wr(8'h08, 32'h0000_0400);
    wr(8'h04, 32'h0000_0400);
    tick(2);
    chk(32'(irq), 32'h0000_0000);
    rd(8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("irq test done");
    base.busyExpected = 1'b1;
    engineEvt <= base;
    busy <= 1'b1;
    tick(6);
    rd(8'h00, 32'h0000_1000, 32'h0000_0000);
    busy <= 1'b0;
    tick(6);
    rd(8'h00, 32'h0000_1000, 32'h0000_1000);
    base = '0;
    clkOn <= 1'b1;
    intReq <= 1'b1;
    tick(40);
    intReq <= 1'b0;
    clkOn <= 1'b0;
    tick(6);
    rd(8'h00, 32'h0000_2000, 32'h0000_2000);
    evRd(chsf_evt_t'(13'h0001), 32'h0000_2000, 32'h0000_0000);
    $display("link test done");
    wr(8'h0C, 32'h0000_0001);
    tick(3);
    #1;
    chk(32'(resetActive), 32'h0000_0001);
    rd(8'h00, 32'h0000_7FFF, 32'h0000_0000);
    waitReset();
    rd(8'h00, 32'h0000_0080, 32'h0000_0080);
    $display("soft reset test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
